// File: logic/twsp_pkg.sv
package twsp_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets on the APB
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_DIV = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;

   // ----------------------------------------------------------------
   // Field positions and masks
   // ----------------------------------------------------------------
   localparam int MODE_ROLE = 0;
   localparam int MODE_EDGE = 1;
   localparam int MODE_IDLE = 2;
   localparam int MODE_EN = 3;
   localparam logic [7:0] MODE_MASK = 8'h0F;
   localparam int DIV_ONE = 7;
   localparam logic [7:0] DIV_MASK = 8'hFF;
   localparam int STAT_BUSY = 0;
   localparam int STAT_RBF = 1;
   localparam int STAT_OVR = 2;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
   localparam logic [4:0] LAST_EDGE = 5'h0F;

   // Shift engine state
   typedef enum logic [0:0] {
      TWSP_IDLE = 1'b0,
      TWSP_RUN = 1'b1
   } twsp_state_e;

endpackage

// File: logic/twsp_sync.sv
`timescale 1ns/100ps
module twsp_sync
   import twsp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin levels in and synchronised levels out
   input wire logic [3:0] async_i,
   output logic [3:0] sync_o
);

   // ----------------------------------------------------------------
   // Two-flop synchroniser; first stage read by second stage only
   // ----------------------------------------------------------------
   logic [3:0] meta;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= 4'hF;
         sync_o <= 4'hF;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule

// File: logic/twsp_clkdiv.sv
`timescale 1ns/100ps
module twsp_clkdiv
   import twsp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic run_i,
   input wire logic [7:0] half_i,
   // One-cycle pulse per half period
   output logic tick_o
);

   // ----------------------------------------------------------------
   // Half-period counter, restarted whenever the engine stops
   // ----------------------------------------------------------------
   logic [7:0] cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt <= 8'h00;
         tick_o <= 1'b0;
      end else if (cnt == half_i - 8'h01) begin
         cnt <= 8'h00;
         tick_o <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
         tick_o <= 1'b0;
      end
   end

endmodule

// File: logic/twsp_regs.sv
`timescale 1ns/100ps
// Operation
// - one byte data register carries all traffic
// - data read returns the receive buffer byte
// - pending shifter byte moves to buffer after read
// - data write loads shifter, dropping pending byte
// - transmit MSB first on role output line
// - data buffer and shifter have no reset
// - mode and divider registers reset to zero
// - role bit zero slave, one master
// - edge bit picks sample and output edges
// - idle bit sets shift clock resting level
// - enable bit; clearing clears busy, full, overrun
// - defined pin states while port disabled
// - divider only matters in master role
// - divide-by-one bit runs fastest shift clock
// - master overrun when new start finds both full
module twsp_regs
   import twsp_pkg::*;
(
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic [31:0] PRDATA_O,
   // Shift clock pin
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE_N_O,
   // Slave select pin, input only
   input wire logic SLAVE_SELECT_N_I,
   // Master-out slave-in line
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE_N_O,
   // Master-in slave-out line
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE_N_O,
   // Slave ready pin, released in this block
   output logic SLAVE_READY_N_O,
   output logic SLAVE_READY_N_OE_N_O
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] div;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] rbuf;
      logic rbf;
      logic pend;
      logic ovr;
      logic busy;
      twsp_state_e st;
      logic [4:0] edges;
      logic sck;
      logic prev_sck;
      logic sck_oe_n;
      logic mosi;
      logic mosi_oe_n;
      logic miso;
      logic miso_oe_n;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic rdy;
   } twsp_regs_s;

   twsp_regs_s r;
   twsp_regs_s next_r;

   // Address decode, shared by read mux and write path
   function automatic logic [1:0] reg_index(input logic [7:0] a);
      case (a)
         OFF_DATA: reg_index = 2'h0;
         OFF_MODE: reg_index = 2'h1;
         OFF_DIV: reg_index = 2'h2;
         default: reg_index = 2'h3;
      endcase
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFF_DATA) || (a == OFF_MODE) || (a == OFF_DIV) || (a == OFF_STAT);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers and master clock divider
   // ----------------------------------------------------------------
   logic [3:0] pins_s;
   logic s_sck;
   logic s_ss_n;
   logic s_mosi;
   logic s_miso;
   logic tick;
   logic [7:0] half;
   logic master_run;

   twsp_sync u_sync (
      .clk_i(MCLK_I),
      .rst_i(SYS_RST_I),
      .async_i({SCK_I, SLAVE_SELECT_N_I, MOSI_I, MISO_I}),
      .sync_o(pins_s)
   );

   assign s_sck = pins_s[3];
   assign s_ss_n = pins_s[2];
   assign s_mosi = pins_s[1];
   assign s_miso = pins_s[0];

   // Half period is one cycle in divide-by-one; outputs are flops, so
   // the pin cannot toggle faster than half the system clock
   assign half = r.div[DIV_ONE] ? 8'h01 : {1'b0, r.div[6:0]} + 8'h01;
   assign master_run = r.mode[MODE_ROLE] && (r.st == TWSP_RUN);

   twsp_clkdiv u_div (
      .clk_i(MCLK_I),
      .rst_i(SYS_RST_I),
      .run_i(master_run),
      .half_i(half),
      .tick_o(tick)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic master;
      logic en;
      logic active;
      logic rise;
      logic fall;
      logic smp;
      logic outd;
      logic in_bit;
      logic wr;
      logic rd;
      logic [7:0] rx_next;
      next_r = r;
      master = r.mode[MODE_ROLE];
      en = r.mode[MODE_EN];
      active = master ? (r.st == TWSP_RUN) : (en && !s_ss_n);
      rise = master ? (tick && !r.sck) : (active && s_sck && !r.prev_sck);
      fall = master ? (tick && r.sck) : (active && !s_sck && r.prev_sck);
      // Normal mode samples on rise, alternate on fall
      smp = r.mode[MODE_EDGE] ? fall : rise;
      outd = r.mode[MODE_EDGE] ? rise : fall;
      in_bit = master ? s_miso : s_mosi;
      wr = PSEL_I && PENABLE_I && r.pready && PWRITE_I;
      rd = PSEL_I && PENABLE_I && r.pready && !PWRITE_I;
      rx_next = smp ? {r.rx[6:0], in_bit} : r.rx;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      next_r.prev_sck = s_sck;

      // Shift engine: one bit per shift clock period
      if (active && master && tick) begin
         next_r.sck = ~r.sck;
      end
      if (active && (rise || fall)) begin
         next_r.edges = r.edges + 5'h01;
         next_r.busy = 1'b1;
         next_r.rx = rx_next;
         // A leading output edge keeps the MSB for one more shift clock period
         if (outd && (r.edges != 5'h00)) begin
            next_r.tx = {r.tx[6:0], 1'b0};
         end
         if (r.edges == LAST_EDGE) begin
            next_r.edges = 5'h00;
            next_r.busy = 1'b0;
            next_r.st = TWSP_IDLE;
         end
      end
      // Slave deselect realigns the bit count with the master
      if (!master && s_ss_n) begin
         next_r.edges = 5'h00;
         next_r.busy = 1'b0;
      end

      // Buffer read pops the pending shifter byte
      if (rd && (reg_index(PADDR_I) == 2'h0)) begin
         next_r.rbf = r.pend;
         next_r.pend = 1'b0;
         if (r.pend) begin
            next_r.rbuf = r.rx;
         end
      end
      // Completed byte goes to buffer, or waits in shifter
      if (active && (rise || fall) && (r.edges == LAST_EDGE)) begin
         if (!next_r.rbf) begin
            next_r.rbuf = rx_next;
            next_r.rbf = 1'b1;
         end else begin
            next_r.pend = 1'b1;
         end
      end

      // Register writes
      if (wr) begin
         case (reg_index(PADDR_I))
            2'h0: begin
               next_r.tx = PWDATA_I[7:0];
               next_r.pend = 1'b0;
               if (master && en) begin
                  next_r.st = TWSP_RUN;
                  next_r.busy = 1'b1;
                  next_r.edges = 5'h00;
                  if (r.rbf && r.pend) begin
                     next_r.ovr = 1'b1;
                  end
               end
            end
            2'h1: next_r.mode = PWDATA_I[7:0] & MODE_MASK;
            2'h2: next_r.div = PWDATA_I[7:0] & DIV_MASK;
            default: next_r.mode = next_r.mode;
         endcase
      end
      // Disabling stops the engine and clears all status
      if (!next_r.mode[MODE_EN]) begin
         next_r.busy = 1'b0;
         next_r.rbf = 1'b0;
         next_r.ovr = 1'b0;
         next_r.pend = 1'b0;
         next_r.st = TWSP_IDLE;
         next_r.edges = 5'h00;
      end
      // Master clock rests at the idle level between bytes
      if (!(next_r.mode[MODE_ROLE] && (next_r.st == TWSP_RUN))) begin
         next_r.sck = next_r.mode[MODE_IDLE];
      end

      // Setup phase: prepare answer, zero wait state
      if (PSEL_I && !PENABLE_I) begin
         next_r.pready = 1'b1;
         next_r.pslverr = !is_mapped(PADDR_I);
         case (reg_index(PADDR_I))
            2'h0: next_r.prdata = {24'h000000, r.rbuf};
            2'h1: next_r.prdata = {24'h000000, r.mode};
            2'h2: next_r.prdata = {24'h000000, r.div};
            default: begin
               next_r.prdata = 32'h00000000;
               if (is_mapped(PADDR_I)) begin
                  next_r.prdata[STAT_BUSY] = r.busy;
                  next_r.prdata[STAT_RBF] = r.rbf;
                  next_r.prdata[STAT_OVR] = r.ovr;
               end
            end
         endcase
      end

      // Pin drive; enables are low while driving
      next_r.sck_oe_n = !next_r.mode[MODE_ROLE];
      next_r.mosi_oe_n = !next_r.mode[MODE_ROLE];
      next_r.mosi = next_r.mode[MODE_EN] ? next_r.tx[7] : 1'b0;
      next_r.miso_oe_n = next_r.mode[MODE_ROLE] || !next_r.mode[MODE_EN] || s_ss_n;
      next_r.miso = next_r.tx[7];
      next_r.rdy = 1'b1;
   end

   // ----------------------------------------------------------------
   // State register; data bytes deliberately keep no reset value
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         r.mode <= MODE_RESET;
         r.div <= DIV_RESET;
         r.rbf <= 1'b0;
         r.pend <= 1'b0;
         r.ovr <= 1'b0;
         r.busy <= 1'b0;
         r.st <= TWSP_IDLE;
         r.edges <= 5'h00;
         r.sck <= 1'b0;
         r.prev_sck <= 1'b1;
         r.sck_oe_n <= 1'b1;
         r.mosi <= 1'b0;
         r.mosi_oe_n <= 1'b1;
         r.miso <= 1'b0;
         r.miso_oe_n <= 1'b1;
         r.pready <= 1'b0;
         r.pslverr <= 1'b0;
         r.prdata <= 32'h00000000;
         r.rdy <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state flops
   assign PREADY_O = r.pready;
   assign PSLVERR_O = r.pslverr;
   assign PRDATA_O = r.prdata;
   assign SCK_O = r.sck;
   assign SCK_OE_N_O = r.sck_oe_n;
   assign MOSI_O = r.mosi;
   assign MOSI_OE_N_O = r.mosi_oe_n;
   assign MISO_O = r.miso;
   assign MISO_OE_N_O = r.miso_oe_n;

   // Ready pin is not modelled here: held released from a flop
   assign SLAVE_READY_N_O = r.rdy;
   assign SLAVE_READY_N_OE_N_O = r.rdy;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   sequence s_setup;
      PSEL_I && !PENABLE_I;
   endsequence

   sequence s_data_wr;
      PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && (PADDR_I == OFF_DATA);
   endsequence

   sequence s_data_rd;
      PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && (PADDR_I == OFF_DATA);
   endsequence

   apb_answer_a: assert property (s_setup |=> PREADY_O ##1 !PREADY_O)
      else $error("APB answer not a single-cycle ready");

   rd_pop_a: assert property (s_data_rd and (r.rbf && r.pend) |=> r.rbf && !r.pend)
      else $error("Pending byte not moved to buffer after read");

   wr_load_a: assert property (s_data_wr |=> (r.tx == $past(PWDATA_I[7:0])) && !r.pend)
      else $error("Data write did not load the shifter");

   msb_first_a: assert property (s_data_wr and r.mode[MODE_EN] |=> MOSI_O == $past(PWDATA_I[7]))
      else $error("MSB not presented first");

   reset_zero_a: assert property ($fell(SYS_RST_I) |-> (r.mode == 8'h00) && (r.div == 8'h00))
      else $error("Control registers not cleared by reset");

   slave_pins_a: assert property (!r.mode[MODE_ROLE] |-> SCK_OE_N_O && MOSI_OE_N_O)
      else $error("Slave drives clock or master output line");

   idle_level_a: assert property (r.mode[MODE_ROLE] && (r.st == TWSP_IDLE) |-> SCK_O == r.mode[MODE_IDLE])
      else $error("Idle shift clock at wrong level");

   disable_clr_a: assert property (!r.mode[MODE_EN] |-> !r.busy && !r.rbf && !r.ovr)
      else $error("Status left set while disabled");

   overrun_a: assert property (s_data_wr and (r.mode[MODE_ROLE] && r.mode[MODE_EN] && r.rbf && r.pend) |=> r.ovr)
      else $error("Overrun not flagged");

   slave_nodiv_a: assert property (!r.mode[MODE_ROLE] |-> !master_run)
      else $error("Divider running in slave role");

endmodule

// File: verif/twsp_slave_model.sv
`timescale 1ns/100ps
module twsp_slave_model (
   // Serial pins seen from the far side
   input wire logic sck_i,
   input wire logic sel_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   // Mode and data of the model
   input wire logic edge_i,
   input wire logic [7:0] tx_i,
   output logic [7:0] rx_o
);
   // ----------------------------------------------------------------
   // Behavioural slave, one byte per select
   // ----------------------------------------------------------------
   logic [7:0] sh;
   int cnt;

   initial begin
      miso_o = 1'b0;
      rx_o = 8'h00;
      sh = 8'h00;
      cnt = 0;
   end

   // Select low loads the byte and shows its MSB at once
   always @(negedge sel_n_i) begin
      sh = tx_i;
      cnt = 0;
      miso_o = sh[7];
   end

   // Released line shows the inverse, not a stale copy
   always @(posedge sel_n_i) begin
      miso_o = ~miso_o;
   end

   // Sample on one edge, shift on the other; first output edge holds
   always @(sck_i) begin
      if (!sel_n_i) begin
         if (sck_i != edge_i) begin
            rx_o = {rx_o[6:0], mosi_i};
            cnt = cnt + 1;
         end else if (cnt != 0 && cnt < 8) begin
            sh = sh << 1;
            miso_o = sh[7];
         end
      end
   end
endmodule

// File: verif/test_twsp_regs.sv
`timescale 1ns/100ps
module test_twsp_regs
   import twsp_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic sel_n = 1'b1, edge_m = 1'b0, m_sck = 1'b0, m_mosi = 1'b0;
   logic [7:0] ptx = 8'h00;
   logic [7:0] prx;
   logic pready, perr, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
   logic rdy_n, rdy_oe_n, part_miso, sck_q;
   logic [31:0] prdata;
   int mismatches = 0, samples_checked = 0, half_len = 0, cyc = 0;

   // Wire levels from all drivers; bench plays master in slave role
   wire sck_w = sck_oe_n ? m_sck : sck_o;
   wire mosi_w = mosi_oe_n ? m_mosi : mosi_o;
   wire miso_w = miso_oe_n ? part_miso : miso_o;

   always #2 clk = ~clk;

   twsp_regs uut (.MCLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
      .PSLVERR_O(perr), .PRDATA_O(prdata), .SCK_I(sck_w), .SCK_O(sck_o),
      .SCK_OE_N_O(sck_oe_n), .SLAVE_SELECT_N_I(sel_n), .MOSI_I(mosi_w),
      .MOSI_O(mosi_o), .MOSI_OE_N_O(mosi_oe_n), .MISO_I(miso_w), .MISO_O(miso_o),
      .MISO_OE_N_O(miso_oe_n), .SLAVE_READY_N_O(rdy_n),
      .SLAVE_READY_N_OE_N_O(rdy_oe_n));

   twsp_slave_model part (.sck_i(sck_w), .sel_n_i(sel_n), .mosi_i(mosi_w),
      .miso_o(part_miso), .edge_i(edge_m), .tx_i(ptx), .rx_o(prx));

   // Length of the last shift clock half period, in system cycles
   always @(posedge clk) begin
      sck_q <= sck_o;
      if (sck_o !== sck_q) begin
         half_len <= cyc;
         cyc <= 1;
      end else begin
         cyc <= cyc + 1;
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask

   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 1, 0);
      r = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x, input string name);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(name, {24'h0, x}, r);
   endtask

   // Master byte: partner answers rx, bench sends tx
   task automatic xfer(input logic [7:0] mode, input logic [7:0] div,
         input logic [7:0] tx, input logic [7:0] rx);
      logic [31:0] r;
      logic e;
      int n;
      wr(OFF_MODE, mode);
      wr(OFF_DIV, div);
      chk("sck_idle_before", mode[MODE_IDLE], sck_o);
      edge_m <= mode[MODE_EDGE];
      ptx <= rx;
      @(posedge clk);
      sel_n <= 1'b0;
      wr(OFF_DATA, tx);
      n = 0;
      do begin
         apb(1'b0, OFF_STAT, 32'h0, r, e);
         n++;
      end while (r[STAT_BUSY] !== 1'b0 && n < 300);
      chk("busy_clear", 0, r[STAT_BUSY]);
      chk("mosi_byte", tx, prx);
      chk("half_period", div[DIV_ONE] ? 1 : div[6:0] + 1, half_len);
      chk("sck_idle_after", mode[MODE_IDLE], sck_o);
      sel_n <= 1'b1;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rd(OFF_MODE, MODE_RESET, "mode_reset");
      rd(OFF_DIV, DIV_RESET, "div_reset");
      rd(OFF_STAT, 8'h00, "stat_reset");
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk("unmapped_err", 1, e);
      chk("unmapped_data", 0, r);
      wr(OFF_MODE, 8'hF0);
      rd(OFF_MODE, 8'h00, "mode_reserved");
   endtask

   // Every edge and idle combination, plus divide-by-one
   task automatic t_modes();
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 4; i++) begin
         xfer(8'h09 | (i << 1), 8'h03, 8'hA5 ^ i, 8'h3C + i);
         rd(OFF_STAT, 8'h02, "rbf_set");
         rd(OFF_DATA, 8'h3C + i, "rx_byte");
         rd(OFF_STAT, 8'h00, "rbf_clear");
      end
      xfer(8'h09, 8'h80, 8'hC3, 8'h00);
      apb(1'b0, OFF_DATA, 32'h0, r, e);
   endtask

   // Second byte waits in the shifter; a third write drops it
   task automatic t_overrun();
      // Checked byte needs three cycles per half period for the sync
      xfer(8'h09, 8'h02, 8'h01, 8'h11);
      xfer(8'h09, 8'h01, 8'h02, 8'h22);
      rd(OFF_STAT, 8'h02, "rbf_pending");
      xfer(8'h09, 8'h02, 8'h03, 8'h33);
      rd(OFF_STAT, 8'h06, "overrun_set");
      rd(OFF_DATA, 8'h11, "first_byte");
      rd(OFF_DATA, 8'h33, "pending_moved");
      rd(OFF_STAT, 8'h04, "overrun_stays");
   endtask

   task automatic t_pins();
      wr(OFF_MODE, 8'h01);
      rd(OFF_STAT, 8'h00, "disable_clears");
      chk("m_sck_oe", 0, sck_oe_n);
      chk("m_sck_lvl", 0, sck_o);
      chk("m_mosi_oe", 0, mosi_oe_n);
      chk("m_miso_oe", 1, miso_oe_n);
      chk("ready_oe", 1, rdy_oe_n);
      chk("ready_lvl", 1, rdy_n);
      chk("m_mosi_lvl", 0, mosi_o);
      wr(OFF_MODE, 8'h05);
      repeat (2) @(posedge clk);
      chk("m_sck_idle1", 1, sck_o);
      wr(OFF_MODE, 8'h00);
      repeat (2) @(posedge clk);
      chk("s_sck_oe", 1, sck_oe_n);
      chk("s_mosi_oe", 1, mosi_oe_n);
      chk("s_miso_oe", 1, miso_oe_n);
      wr(OFF_MODE, 8'h08);
      wr(OFF_DATA, 8'h80);
      sel_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk("s_no_sck", 1, sck_oe_n);
      chk("s_miso_oe_on", 0, miso_oe_n);
      chk("s_miso_msb", 1, miso_o);
      sel_n <= 1'b1;
   endtask

   // Slave byte: bench plays master, four cycles per half period so
   // that the pin synchronisers keep up
   task automatic t_slave();
      logic [7:0] got;
      logic [7:0] sent;
      sent = 8'h5A;
      got = 8'h00;
      wr(OFF_MODE, 8'h08);
      wr(OFF_DATA, 8'hC6);
      sel_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int b = 7; b >= 0; b--) begin
         m_mosi <= sent[b];
         repeat (4) @(posedge clk);
         got[b] = miso_w;
         m_sck <= 1'b1;
         repeat (4) @(posedge clk);
         m_sck <= 1'b0;
      end
      repeat (6) @(posedge clk);
      chk("slave_miso", 8'hC6, got);
      rd(OFF_STAT, 8'h02, "slave_rbf");
      rd(OFF_DATA, sent, "slave_rx");
      sel_n <= 1'b1;
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_modes();
      t_overrun();
      t_pins();
      t_slave();
      stop_test();
   end

   // Whole run is under a thousand cycles; far beyond that is a hang
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
endmodule
